// >>> inc/sps_pkg.sv
// ==========================================================
// shared constants and types of the serial port status block
package sps_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_BUF    = 8'h08;
  // status register bit positions
  localparam int         BIT_SAMPLE  = 7;
  localparam int         BIT_CKE     = 6;
  localparam int         BIT_FULL    = 0;
  // control register bit positions
  localparam int         CTRL_MASTER = 0;
  localparam int         CTRL_IDLE   = 1;
  localparam int         CTRL_BUSY   = 2;
  localparam int         CTRL_FULL   = 3;
  // values after reset
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] BUF_RST     = 8'h00;
  // counts of cycles, ticks, bits and fifo entries
  localparam int         HALF_CYC    = 4;
  localparam int         BYTE_BITS   = 8;
  localparam int         LAST_TICK   = 17;
  localparam int         TX_DEPTH    = 16;

  typedef struct packed {
    logic sample;
    logic cke;
  } sps_phase_type;

  typedef struct packed {
    logic lead;
    logic trail;
    logic last;
  } sps_edge_type;
endpackage : sps_pkg

// >>> hdl/sps_port.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
// ==========================================================
// transmit fifo, flip-flop storage
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sps_pkg::TX_DEPTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
  assign out_valid = (wptr_q != rptr_q);
  assign out_data  = mem_q[rptr_q[AW-1:0]];

  // storage write
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem_q[wptr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule : sps_fifo

// ==========================================================
// serial port with status and phase register
module sps_port #(
  parameter int HALF_CYC = sps_pkg::HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        sel_n_in
);
  typedef enum logic {ST_IDLE, ST_RUN} sps_state_type;

  sps_state_type        state_q;
  sps_pkg::sps_phase_type phase_q;
  sps_pkg::sps_edge_type  ev;
  logic                 master_q, ckp_q, full_q, skip_q, sclk_q;
  logic [7:0]           rx_q, rx_sh_q, tx_sh_q, div_q;
  logic [4:0]           tick_q;
  logic [2:0]           bit_q;
  logic [31:0]          prdata_q;
  logic                 sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2, sel_n_s1, sel_n_s2;
  logic                 tick, change, mid, endsamp, samp, shift, start, byte_done, load;
  logic                 acc, wr_buf, rd_buf, buf_sel, tx_ready, tx_valid;
  logic [7:0]           tx_data;
  logic [4:0]           tnum;

  // ========================================================
  // bus decode; writes to a full fifo stall the bus
  assign acc     = psel && penable;
  assign buf_sel = (paddr == sps_pkg::ADDR_BUF);
  assign wr_buf  = acc && pwrite && buf_sel && tx_ready;
  assign rd_buf  = acc && !pwrite && buf_sel;
  assign pready  = !(psel && pwrite && buf_sel && !tx_ready);
  assign pslverr = acc && !(buf_sel || paddr == sps_pkg::ADDR_STATUS || paddr == sps_pkg::ADDR_CTRL);
  assign prdata  = prdata_q;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      case (paddr)
        sps_pkg::ADDR_STATUS: begin
          prdata_q[sps_pkg::BIT_SAMPLE] <= phase_q.sample;
          prdata_q[sps_pkg::BIT_CKE]    <= phase_q.cke;
          prdata_q[sps_pkg::BIT_FULL]   <= full_q;
        end
        sps_pkg::ADDR_CTRL: begin
          prdata_q[sps_pkg::CTRL_MASTER] <= master_q;
          prdata_q[sps_pkg::CTRL_IDLE]   <= ckp_q;
          prdata_q[sps_pkg::CTRL_BUSY]   <= (state_q == ST_RUN);
          prdata_q[sps_pkg::CTRL_FULL]   <= !tx_ready;
        end
        sps_pkg::ADDR_BUF: prdata_q[7:0] <= rx_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers; two-wire flag writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q  <= sps_pkg::STATUS_RST[sps_pkg::BIT_SAMPLE:sps_pkg::BIT_CKE];
      master_q <= sps_pkg::CTRL_RST[sps_pkg::CTRL_MASTER];
      ckp_q    <= sps_pkg::CTRL_RST[sps_pkg::CTRL_IDLE];
    end else if (acc && pwrite) begin
      if (paddr == sps_pkg::ADDR_STATUS) begin
        phase_q <= pwdata[sps_pkg::BIT_SAMPLE:sps_pkg::BIT_CKE];
      end
      if (paddr == sps_pkg::ADDR_CTRL) begin
        master_q <= pwdata[sps_pkg::CTRL_MASTER];
        ckp_q    <= pwdata[sps_pkg::CTRL_IDLE];
      end
    end
  end

  // ========================================================
  // two-flop synchronisers for the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {sdi_s1, sdi_s2}            <= 2'h0;
      {sel_n_s1, sel_n_s2}        <= 2'h3;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {sclk_in, sclk_s1, sclk_s2};
      {sdi_s1, sdi_s2}            <= {sdi, sdi_s1};
      {sel_n_s1, sel_n_s2}        <= {sel_n_in, sel_n_s1};
    end
  end

  sps_fifo #(.WIDTH(8), .DEPTH(sps_pkg::TX_DEPTH)) u_txq (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (acc && pwrite && buf_sel),
    .in_ready  (tx_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_valid),
    .out_ready (load),
    .out_data  (tx_data)
  );

  // ========================================================
  // clock edges: divider ticks in master, pin edges in slave
  assign tick = (state_q == ST_RUN) && master_q && (div_q == 8'(HALF_CYC - 1));
  assign tnum = tick_q + 5'h01;
  always_comb begin
    ev = '0;
    if (master_q) begin
      ev.lead  = tick && tnum[0] && (tnum != 5'(sps_pkg::LAST_TICK));
      ev.trail = tick && !tnum[0];
      ev.last  = tick && (tnum == 5'(sps_pkg::LAST_TICK));
    end else if (state_q == ST_RUN) begin
      ev.lead  = (sclk_s2 != sclk_s3) && (sclk_s2 != ckp_q);
      ev.trail = (sclk_s2 != sclk_s3) && (sclk_s2 == ckp_q);
    end
  end

  assign change  = phase_q.cke ? ev.trail : ev.lead;
  assign mid     = phase_q.cke ? ev.lead : ev.trail;
  assign shift   = change && !skip_q;
  assign endsamp = shift || (ev.last && !phase_q.cke);
  assign samp    = (master_q && phase_q.sample) ? endsamp : mid;
  assign byte_done = samp && (bit_q == 3'(sps_pkg::BYTE_BITS - 1));
  assign start   = (state_q == ST_IDLE) && (master_q ? tx_valid : !sel_n_s2);
  // slave reloads after each byte while still selected
  assign load    = (start || (byte_done && !master_q)) && tx_valid;

  // sequencer state, divider and tick count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      div_q   <= 8'h00;
      tick_q  <= 5'h00;
    end else begin
      div_q <= tick ? 8'h00 : ((state_q == ST_RUN) ? div_q + 8'h01 : 8'h00);
      if (tick) begin
        tick_q <= tnum;
      end
      if (start) begin
        state_q <= ST_RUN;
        tick_q  <= 5'h00;
      end else if (ev.last || (!master_q && sel_n_s2)) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // master clock pin: toggles on each tick but the last, rests at idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      sclk_q <= ckp_q;
    end else if (tick && !ev.last) begin
      sclk_q <= !sclk_q;
    end
  end

  // shift registers; first change edge skipped when it is the leading edge (cke clear)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      bit_q   <= 3'h0;
      skip_q  <= 1'b0;
    end else begin
      if (start || (byte_done && !master_q)) begin
        tx_sh_q <= tx_valid ? tx_data : 8'h00;
        skip_q  <= !phase_q.cke;
      end else if (change) begin
        skip_q <= 1'b0;
        if (shift) begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
      if (start) begin
        bit_q <= 3'h0;
      end else if (samp) begin
        rx_sh_q <= {rx_sh_q[6:0], sdi_s2};
        bit_q   <= bit_q + 3'h1;
      end
    end
  end

  // received byte and buffer-full flag; a new byte wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= sps_pkg::BUF_RST;
      full_q <= sps_pkg::STATUS_RST[sps_pkg::BIT_FULL];
    end else begin
      if (byte_done) begin
        rx_q   <= {rx_sh_q[6:0], sdi_s2};
        full_q <= 1'b1;
      end else if (rd_buf) begin
        full_q <= 1'b0;
      end
    end
  end

  assign sclk_out = sclk_q;
  assign sclk_oe  = master_q;
  assign sdo      = tx_sh_q[7];
  assign sdo_oe   = master_q || !sel_n_s2;

  // ========================================================
  // checks
  a_full_set: assert property (@(posedge pclk) disable iff (!presetn)
    byte_done |=> full_q && rx_q == $past({rx_sh_q[6:0], sdi_s2})) else $error("full flag not set");
  a_full_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_buf && !byte_done |=> !full_q) else $error("full flag not cleared by read");
  a_i2c_zero: assert property (@(posedge pclk) disable iff (!presetn)
    acc && paddr == sps_pkg::ADDR_STATUS |-> prdata[5:1] == 5'h00) else $error("two-wire flags not zero");
  a_out_edge: assert property (@(posedge pclk) disable iff (!presetn)
    master_q && state_q == ST_RUN && $changed(tx_sh_q[7]) && !$past(load) && !$past(start)
    |-> (sclk_q == ckp_q) == phase_q.cke) else $error("output changed on wrong edge");
  a_sample_pt: assert property (@(posedge pclk) disable iff (!presetn)
    master_q && samp |-> (phase_q.sample ? !mid : mid)) else $error("sample point wrong");
  a_byte_len: assert property (@(posedge pclk) disable iff (!presetn)
    master_q && start |-> !byte_done [*8]) else $error("byte too short");
endmodule : sps_port

// >>> test/sps_far_slave.sv
`timescale 1ns/1ns
// ==========================================================
// far-side serial slave: shifts a byte out on sdi, collects sdo
module sps_far_slave (
  input  wire logic       pclk,
  input  wire logic       sclk,
  input  wire logic       sdo,
  input  wire logic       cke,
  input  wire logic       idle,
  input  wire logic       late,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            sdi,
  output logic      [7:0] rx
);
  logic       prev = 1'b0;
  logic       pend = 1'b0;
  logic [7:0] sh   = 8'h00;
  wire        moved = (sclk != prev);
  wire        mid   = moved && ((sclk != idle) == cke);

  // sampled on pclk so sdo is read before the design moves it
  always @(posedge pclk) begin
    prev <= sclk;
    if (load) begin
      sh   <= late ? tx : {tx[6:0], 1'b0};
      sdi  <= late ? ~tx[7] : tx[7];
      pend <= 1'b0;
    end else begin
      if (mid) rx <= {rx[6:0], sdo};
      if (mid) pend <= 1'b1;
      // late mode moves data half a bit later, so only end sampling sees it
      if (late ? mid : (pend && moved && !mid)) begin
        sdi  <= sh[7];
        sh   <= {sh[6:0], ~sh[7]};
        pend <= 1'b0;
      end
    end
  end
endmodule : sps_far_slave

// >>> test/sps_port_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// bench top: bus tasks, far-side slave, serial tests
module sps_port_tb_top;
  localparam logic [7:0] SB = 8'h96;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        sclk_in  = 1'b0;
  logic        sel_n_in = 1'b1;
  logic        tb_sdi   = 1'b0;
  logic        cke      = 1'b0;
  logic        idle     = 1'b0;
  logic        late     = 1'b0;
  logic        load     = 1'b0;
  logic [7:0]  p_tx     = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk_out;
  logic        sclk_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        p_sdi;
  logic [7:0]  p_rx;
  logic        err;
  logic [31:0] q;
  int          fails       = 0;
  int          checks_done = 0;

  // clock
  always #2 pclk = ~pclk;

  sps_port i_sps_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdi(sel_n_in ? p_sdi : tb_sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .sel_n_in(sel_n_in));
  sps_far_slave i_sps_far_slave (.pclk(pclk), .sclk(sclk_out), .sdo(sdo), .cke(cke), .idle(idle),
    .late(late), .load(load), .tx(p_tx), .sdi(p_sdi), .rx(p_rx));

  // ==========================================================
  // bus and check tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // polling is bounded; the watchdog covers the rest
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while ((q & m) !== v && n < 1000) begin
      n++;
      apb(1'b0, a, 32'h0);
    end
    // a poll that runs out counts as a mismatch
    chk("poll", v, q & m);
  endtask : poll

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0, q);
    apb(1'b1, 8'h0C, 32'hFF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, sps_pkg::ADDR_STATUS, 32'hFF);
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'hC0, q);
    $display("test registers done");
    // every edge-select and sample-phase pairing, idle level varied
    for (int i = 0; i < 4; i++) begin
      cke  <= i[0];
      late <= i[1];
      idle <= i[0] ^ i[1];
      apb(1'b1, sps_pkg::ADDR_STATUS, {24'h0, i[1], i[0], 6'h0});
      apb(1'b1, sps_pkg::ADDR_CTRL, {30'h0, i[0] ^ i[1], 1'b1});
      p_tx <= 8'h5A + 8'(i);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      apb(1'b1, sps_pkg::ADDR_BUF, 32'hC3 - i);
      poll(sps_pkg::ADDR_STATUS, 32'h1, 32'h1);
      chk("far rx", 32'hC3 - i, {24'h0, p_rx});
      apb(1'b0, sps_pkg::ADDR_BUF, 32'h0);
      chk("rx byte", 32'h5A + i, q);
      apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0);
      chk("status", {24'h0, i[1], i[0], 6'h0}, q);
    end
    $display("test master done");
    // fill the fifo with the link stopped, then drain it
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0);
    for (int i = 0; i < sps_pkg::TX_DEPTH; i++) apb(1'b1, sps_pkg::ADDR_BUF, 32'h10 + i);
    apb(1'b0, sps_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl full", 32'h8, q);
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h1);
    chk("clock drive", 32'h1, {31'h0, sclk_oe});
    repeat (16 * (sps_pkg::LAST_TICK * sps_pkg::HALF_CYC + 8)) @(posedge pclk);
    apb(1'b0, sps_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl idle", 32'h1, q);
    chk("far rx", 32'h1F, {24'h0, p_rx});
    apb(1'b0, sps_pkg::ADDR_BUF, 32'h0);
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'hC0, q);
    $display("test fifo done");
    // slave frame with 10-cycle clock halves, sample bit kept clear
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0);
    sel_n_in <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      repeat (10) @(posedge pclk);
      sclk_in <= 1'b1;
      // data moves on the leading edge so it is settled when the trailing edge samples it
      tb_sdi  <= SB[k];
      repeat (10) @(posedge pclk);
      sclk_in <= 1'b0;
    end
    repeat (10) @(posedge pclk);
    chk("data drive", 32'h1, {31'h0, sdo_oe});
    sel_n_in <= 1'b1;
    poll(sps_pkg::ADDR_STATUS, 32'h1, 32'h1);
    apb(1'b0, sps_pkg::ADDR_BUF, 32'h0);
    chk("slave rx", {24'h0, SB}, q);
    $display("test slave done");
    give_verdict();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule : sps_port_tb_top
